// File: common/edge_irq_pkg.sv
// constants shared by the edge interrupt input block
// assumes a single 50 MHz core clock and a 32-bit classic Wishbone slave port
//
// Operation
// - every on-board digital input may act as an interrupt source
// - each input selects none, rising, falling or both edges
// - each channel keeps exactly one pending event until it is taken
// - further edges on a pending channel are dropped, without any indication
// - a 16-bit triggering module address accompanies each interrupt
// - a 32-bit indicator shows which inputs caused the interrupt
// - no diagnostic data is produced for standard inputs
// - input count and technology-capable count are per-variant parameters
// - a new input delay applies only after the old delay period expired
package edge_irq_pkg;

   // =========================================================
   // variant and identity
   localparam int          N_IN_DFLT     = 24;
   localparam int          N_TECH_DFLT   = 16;
   localparam logic [15:0] MOD_ADDR_DFLT = 16'h007c;

   // =========================================================
   // input delay timing
   localparam int CLK_MHZ     = 50;
   localparam int T_DLY0_US   = 100;
   localparam int T_DLY1_US   = 500;
   localparam int T_DLY2_US   = 3000;
   localparam int T_DLY3_US   = 15000;
   localparam int CNT_DLY0    = T_DLY0_US * CLK_MHZ;
   localparam int CNT_DLY1    = T_DLY1_US * CLK_MHZ;
   localparam int CNT_DLY2    = T_DLY2_US * CLK_MHZ;
   localparam int CNT_DLY3    = T_DLY3_US * CLK_MHZ;
   localparam int FCNT_W      = 20;

   typedef enum logic [1:0] {DLY_0P1, DLY_0P5, DLY_3, DLY_15} dly_sel_t;
   localparam dly_sel_t DLY_SEL_RST = DLY_3;

   // =========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_RISE_EN  = 8'h00;
   localparam logic [7:0] OFF_FALL_EN  = 8'h04;
   localparam logic [7:0] OFF_DELAY    = 8'h08;
   localparam logic [7:0] OFF_PENDING  = 8'h0c;
   localparam logic [7:0] OFF_MOD_ADDR = 8'h10;
   localparam logic [7:0] OFF_INPUTS   = 8'h14;
   localparam logic [7:0] OFF_IRQ_STS  = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;

   // =========================================================
   // interrupt status layout and reset values
   localparam int         STS_W        = 2;
   localparam int         STS_EVT_BIT  = 0;
   localparam int         STS_DLY_BIT  = 1;
   localparam logic [1:0] MASK_RST     = 2'h0;

endpackage

// File: dv/edge_interrupt_inputs_test.sv
// self-checking bench for the edge interrupt input block
// assumes short filter counts (4/8/16/32 cycles) and a 20 ns core clock
`timescale 1ns/1ps
module edge_interrupt_inputs_test;
   import edge_irq_pkg::*;
   localparam int N = 24;
   logic          core_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic          irq, process_interrupt_flag;
   logic [7:0]    wb_adr_i;
   logic [3:0]    wb_sel_i;
   logic [31:0]   wb_dat_i, wb_dat_o, triggering_input_indicator, d;
   logic [N-1:0]  digital_input_channel;
   logic [15:0]   triggering_module_address, tech_input;
   int            miscompares, tests_run;

   edge_interrupt_inputs #(.DLY0_CYC(4), .DLY1_CYC(8), .DLY2_CYC(16), .DLY3_CYC(32)) u_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .digital_input_channel(digital_input_channel),
      .irq(irq), .process_interrupt_flag(process_interrupt_flag),
      .triggering_module_address(triggering_module_address),
      .triggering_input_indicator(triggering_input_indicator), .tech_input(tech_input));
   field_source #(.N(N)) u_src (.core_clk(core_clk), .pins(digital_input_channel));

   // =========================================================
   // bus and compare helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       input logic [3:0] sel = 4'hf);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      wb_sel_i <= sel;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      d = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge core_clk);
      if (n >= 50) check("bus ack", 32'h0, 32'h1);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] sel = 4'hf);
      xfer(1'b1, adr, wd, sel);
   endtask
   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
      xfer(1'b0, adr, 32'h0);
      check(what, d, exp);
   endtask
   // bounded wait for the indicator pins to show a pattern
   task automatic wait_ind(input logic [31:0] exp);
      int n;
      n = 0;
      while (triggering_input_indicator !== exp && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 200) check("indicator wait", triggering_input_indicator, exp);
   endtask
   // request a delay setting and poll until it turns active
   task automatic set_dly(input logic [1:0] v);
      int n;
      n = 0;
      wr(OFF_DELAY, {30'h0, v});
      do begin
         xfer(1'b0, OFF_DELAY, 32'h0);
         n++;
      end while (d[5:4] !== v && n < 20);
   endtask

   // =========================================================
   // scenarios
   task automatic t_reset();
      check("module address pins", {16'h0, triggering_module_address}, 32'h0000_007c);
      check("indicator at reset", triggering_input_indicator, 32'h0);
      rd_chk(OFF_RISE_EN, 32'h0, "rise enable reset");
      rd_chk(OFF_FALL_EN, 32'h0, "fall enable reset");
      rd_chk(OFF_DELAY, 32'h0000_0022, "delay reset");
      rd_chk(OFF_MOD_ADDR, 32'h0000_007c, "module address reg");
      rd_chk(OFF_IRQ_MASK, 32'h0, "mask reset");
      rd_chk(8'h20, 32'h0, "unmapped read");
      // byte lanes: only lane 1 of the enables may change, delay needs lane 0
      wr(OFF_RISE_EN, 32'hffff_ffff, 4'h2);
      rd_chk(OFF_RISE_EN, 32'h0000_ff00, "rise enable byte lane");
      wr(OFF_DELAY, 32'h0000_0003, 4'he);
      rd_chk(OFF_DELAY, 32'h0000_0022, "delay needs lane 0");
   endtask
   task automatic t_modes();
      // mode of channel i is i mod 4: none, rising, falling, both
      wr(OFF_RISE_EN, 32'h00aa_aaaa);
      wr(OFF_FALL_EN, 32'h00cc_cccc);
      u_src.set_pins('1);
      wait_ind(32'h00aa_aaaa);
      rd_chk(OFF_PENDING, 32'h00aa_aaaa, "rising pending");
      wr(OFF_PENDING, 32'h00ff_ffff);
      rd_chk(OFF_PENDING, 32'h0, "ack clears");
      u_src.set_pins('0);
      wait_ind(32'h00cc_cccc);
      rd_chk(OFF_PENDING, 32'h00cc_cccc, "falling pending");
      wr(OFF_PENDING, 32'h00ff_ffff);
      wr(OFF_FALL_EN, 32'h0);
      wr(OFF_RISE_EN, 32'h00ff_ffff);
      u_src.set_pins('1);
      wait_ind(32'h00ff_ffff);
      check("every input a source", triggering_input_indicator, 32'h00ff_ffff);
      rd_chk(OFF_INPUTS, 32'h00ff_ffff, "filtered levels");
      check("tech inputs", {16'h0, tech_input}, 32'h0000_ffff);
      wr(OFF_PENDING, 32'h00ff_ffff);
   endtask
   task automatic t_drop();
      xfer(1'b0, OFF_IRQ_STS, 32'h0);
      wr(OFF_RISE_EN, 32'h0000_0020);
      wr(OFF_FALL_EN, 32'h0000_0020);
      u_src.set_pins(24'hff_ffdf);
      wait_ind(32'h0000_0020);
      check("irq while masked", {31'h0, irq}, 32'h0);
      check("pending flag", {31'h0, process_interrupt_flag}, 32'h1);
      wr(OFF_IRQ_MASK, 32'h1);
      check("irq unmasked", {31'h0, irq}, 32'h1);
      rd_chk(OFF_IRQ_STS, 32'h1, "event status");
      check("irq after read", {31'h0, irq}, 32'h0);
      // the rising edge lands on a channel that is still pending
      u_src.set_pins('1);
      repeat (60) @(posedge core_clk);
      rd_chk(OFF_INPUTS, 32'h00ff_ffff, "level after drop");
      rd_chk(OFF_IRQ_STS, 32'h0, "silent loss");
      rd_chk(OFF_PENDING, 32'h0000_0020, "single pending");
      wr(OFF_PENDING, 32'h0000_0020);
      repeat (30) @(posedge core_clk);
      check("lost edge gone", triggering_input_indicator, 32'h0);
      check("flag cleared", {31'h0, process_interrupt_flag}, 32'h0);
   endtask
   task automatic t_delay();
      set_dly(2'h0);
      check("delay applied", d, 32'h0);
      check("delay status masked", {31'h0, irq}, 32'h0);
      rd_chk(OFF_IRQ_STS, 32'h2, "delay status");
      wr(OFF_RISE_EN, 32'h0000_0040);
      wr(OFF_FALL_EN, 32'h0000_0040);
      u_src.glitch(6);
      repeat (30) @(posedge core_clk);
      check("glitch rejected", triggering_input_indicator, 32'h0);
      u_src.set_pins(24'hff_ffbf);
      wait_ind(32'h0000_0040);
      check("short delay edge", triggering_input_indicator, 32'h0000_0040);
      check("irq on event", {31'h0, irq}, 32'h1);
      wr(OFF_PENDING, 32'h0000_0040);
      rd_chk(OFF_IRQ_STS, 32'h1, "event status after edge");
      // longest delay: a pulse shorter than it must not reach the filter output
      wr(OFF_IRQ_MASK, 32'h2);
      set_dly(2'h3);
      check("long delay applied", d, 32'h33);
      check("delay status unmasked", {31'h0, irq}, 32'h1);
      rd_chk(OFF_IRQ_STS, 32'h2, "delay status again");
      u_src.set_pins('1);
      repeat (20) @(posedge core_clk);
      u_src.set_pins(24'hff_ffbf);
      repeat (60) @(posedge core_clk);
      check("short pulse under long delay", triggering_input_indicator, 32'h0);
      set_dly(2'h1);
      check("mid delay applied", d, 32'h11);
   endtask

   // =========================================================
   // verdict, clock, main sequence and watchdog
   task automatic stop_test();
      if (miscompares == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      sys_rst = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h0;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_modes();
      t_drop();
      t_delay();
      stop_test();
   end
   // the scenarios need several hundred cycles; allow ten thousand
   initial begin
      #200000;
      miscompares++;
      stop_test();
   end
endmodule

// File: dv/field_source.sv
// field pin driver standing in for the sensors on the digital inputs
// assumes the bench calls its tasks from one process timed by core_clk
`timescale 1ns/1ps
module field_source #(
   parameter int N = 24
) (
   // clock
   input  wire logic         core_clk,
   // field pins
   output logic      [N-1:0] pins
);
   initial pins = '0;
   // =========================================================
   // level and glitch drivers
   task automatic set_pins(input logic [N-1:0] v);
      @(posedge core_clk);
      pins <= v;
   endtask
   // one cycle wide, far below any filter window, so it must vanish
   task automatic glitch(input int ch);
      @(posedge core_clk);
      pins[ch] <= ~pins[ch];
      @(posedge core_clk);
      pins[ch] <= ~pins[ch];
   endtask
endmodule

// File: verilog/edge_interrupt_inputs.sv
// edge interrupt inputs: filtered digital inputs raising per-channel events
// assumes field pins are asynchronous and a classic Wishbone master on core_clk
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module edge_interrupt_inputs
   import edge_irq_pkg::*;
#(
   parameter int          N_IN     = N_IN_DFLT,
   parameter int          N_TECH   = N_TECH_DFLT,
   parameter logic [15:0] MOD_ADDR = MOD_ADDR_DFLT,
   parameter int          DLY0_CYC = CNT_DLY0,
   parameter int          DLY1_CYC = CNT_DLY1,
   parameter int          DLY2_CYC = CNT_DLY2,
   parameter int          DLY3_CYC = CNT_DLY3
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // field pins
   input  wire logic [N_IN-1:0]   digital_input_channel,
   // interrupt and start information, technology input levels
   output logic                   irq,
   output logic                   process_interrupt_flag,
   output logic      [15:0]       triggering_module_address,
   output logic      [31:0]       triggering_input_indicator,
   output logic      [N_TECH-1:0] tech_input
);

   // =========================================================
   // state
   logic [N_IN-1:0]   sync1_r;
   logic [N_IN-1:0]   sync2_r;
   logic [N_IN-1:0]   filt_r;
   logic [N_IN-1:0]   prev_r;
   logic [N_IN-1:0]   rise_en_r;
   logic [N_IN-1:0]   fall_en_r;
   logic [N_IN-1:0]   pend_r;
   dly_sel_t          req_sel_r;
   dly_sel_t          act_sel_r;
   logic [FCNT_W-1:0] win_cnt_r;
   logic [STS_W-1:0]  sts_r;
   logic [STS_W-1:0]  mask_r;
   logic              ack_r;
   logic [31:0]       rdat_r;

   // =========================================================
   // bus decode
   wire               req      = wb_cyc_i & wb_stb_i & ~ack_r;
   wire               wr       = req & wb_we_i;
   wire               rd       = req & ~wb_we_i;
   wire               hit_rise = wb_adr_i == OFF_RISE_EN;
   wire               hit_fall = wb_adr_i == OFF_FALL_EN;
   wire               hit_dly  = wb_adr_i == OFF_DELAY;
   wire               hit_pend = wb_adr_i == OFF_PENDING;
   wire               hit_mod  = wb_adr_i == OFF_MOD_ADDR;
   wire               hit_in   = wb_adr_i == OFF_INPUTS;
   wire               hit_sts  = wb_adr_i == OFF_IRQ_STS;
   wire               hit_mask = wb_adr_i == OFF_IRQ_MASK;
   wire [31:0]        be32     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0]        wdat_m   = wb_dat_i & be32;
   wire [N_IN-1:0]    be_n     = be32[N_IN-1:0];
   wire [N_IN-1:0]    wdat_n   = wdat_m[N_IN-1:0];

   wire [N_IN-1:0]    rise_en_nxt = (wr & hit_rise) ? ((rise_en_r & ~be_n) | wdat_n) : rise_en_r;
   wire [N_IN-1:0]    fall_en_nxt = (wr & hit_fall) ? ((fall_en_r & ~be_n) | wdat_n) : fall_en_r;
   wire               dly_wr      = wr & hit_dly & wb_sel_i[0];
   wire               mask_wr     = wr & hit_mask & wb_sel_i[0];

   // =========================================================
   // delay window: old period ends before new one takes over
   wire [FCNT_W-1:0]  lim_w = (act_sel_r == DLY_0P1) ? FCNT_W'(DLY0_CYC) :
                              (act_sel_r == DLY_0P5) ? FCNT_W'(DLY1_CYC) :
                              (act_sel_r == DLY_3)   ? FCNT_W'(DLY2_CYC) :
                                                       FCNT_W'(DLY3_CYC);
   wire [FCNT_W-1:0]  lim_m1   = lim_w - FCNT_W'(1);
   wire               win_done = win_cnt_r >= lim_m1;
   wire               dly_evt  = win_done & (req_sel_r != act_sel_r);

   // =========================================================
   // edge capture
   // rising, falling or both per input
   wire [N_IN-1:0]    edge_v = (filt_r & ~prev_r & rise_en_r) | (~filt_r & prev_r & fall_en_r);
   wire [N_IN-1:0]    ack_vec = (wr & hit_pend) ? wdat_n : '0;
   wire [N_IN-1:0]    keep_v  = pend_r & ~ack_vec;
   // edges on a held channel vanish
   wire [N_IN-1:0]    pend_nxt = keep_v | edge_v;
   wire               new_evt  = |(edge_v & ~keep_v);
   wire [STS_W-1:0]   sts_set  = {dly_evt, new_evt};
   // read clears, but a new event in that cycle still lands
   wire [STS_W-1:0]   sts_nxt  = ((rd & hit_sts) ? '0 : sts_r) | sts_set;

   // =========================================================
   // read mux; no diagnostic register, unmapped reads zero
   wire [31:0]        rdat_w = hit_rise ? 32'(rise_en_r) :
                               hit_fall ? 32'(fall_en_r) :
                               hit_dly  ? {26'h0, act_sel_r, 2'h0, req_sel_r} :
                               hit_pend ? 32'(pend_r) :
                               hit_mod  ? {16'h0, MOD_ADDR} :
                               hit_in   ? 32'(filt_r) :
                               hit_sts  ? 32'(sts_r) :
                               hit_mask ? 32'(mask_r) : 32'h0;

   // =========================================================
   // registers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= digital_input_channel;
         sync2_r <= sync1_r;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rise_en_r <= '0;
         fall_en_r <= '0;
         mask_r    <= MASK_RST;
         req_sel_r <= DLY_SEL_RST;
      end else begin
         rise_en_r <= rise_en_nxt;
         fall_en_r <= fall_en_nxt;
         if (mask_wr) begin
            mask_r <= wb_dat_i[STS_W-1:0];
         end
         if (dly_wr) begin
            req_sel_r <= dly_sel_t'(wb_dat_i[1:0]);
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         act_sel_r <= DLY_SEL_RST;
         win_cnt_r <= '0;
      end else if (win_done) begin
         act_sel_r <= req_sel_r;
         win_cnt_r <= '0;
      end else begin
         win_cnt_r <= win_cnt_r + FCNT_W'(1);
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_r <= '0;
         pend_r <= '0;
         sts_r  <= '0;
      end else begin
         prev_r <= filt_r;
         pend_r <= pend_nxt;
         sts_r  <= sts_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0;
      end else begin
         ack_r  <= req;
         if (rd) begin
            rdat_r <= rdat_w;
         end
      end
   end

   // =========================================================
   // every input gets its own filter and can raise events
   // a pin must stay at its new level for a whole delay before it is seen
   for (genvar i = 0; i < N_IN; i++) begin : g_ch
      logic [FCNT_W-1:0] cnt_r;
      wire               diff = sync2_r[i] ^ filt_r[i];
      always_ff @(posedge core_clk or posedge sys_rst) begin
         if (sys_rst) begin
            cnt_r     <= '0;
            filt_r[i] <= 1'b0;
         end else if (!diff) begin
            cnt_r     <= '0;
         end else if (cnt_r >= lim_m1) begin
            cnt_r     <= '0;
            filt_r[i] <= sync2_r[i];
         end else begin
            cnt_r     <= cnt_r + FCNT_W'(1);
         end
      end
   end

   // =========================================================
   // outputs
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;
   assign irq      = |(sts_r & mask_r);
   assign process_interrupt_flag = |pend_r;
   assign triggering_module_address = MOD_ADDR;
   assign triggering_input_indicator = 32'(pend_r);
   // low inputs shared with technology functions
   assign tech_input = filt_r[N_TECH-1:0];

   // =========================================================
   // assertions
   localparam int ACK_MIN = 1;
   localparam int ACK_MAX = 1;

   property p_ack_resp;
      @(posedge core_clk) disable iff (sys_rst)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |-> ##[ACK_MIN:ACK_MAX] wb_ack_o;
   endproperty

   AST_ACK_RESP: assert property (p_ack_resp)
      else $error("request not acknowledged in one cycle");

   AST_ACK_PULSE: assert property (@(posedge core_clk) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   AST_PEND_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
      1'b1 |=> ((pend_r & $past(keep_v)) == $past(keep_v)))
      else $error("pending event lost without acknowledge");

   AST_PEND_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
      (edge_v != '0) |=> ((pend_r & $past(edge_v)) == $past(edge_v)) && process_interrupt_flag)
      else $error("edge not captured as pending");

   AST_NO_SPUR: assert property (@(posedge core_clk) disable iff (sys_rst)
      1'b1 |=> ((pend_r & ~$past(pend_r) & ~$past(edge_v)) == '0))
      else $error("pending set without an edge");

   AST_NO_EDGE_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
      ((rise_en_r | fall_en_r) == '0) |-> (edge_v == '0))
      else $error("edge reported on a disabled input");

   AST_DROP_QUIET: assert property (@(posedge core_clk) disable iff (sys_rst)
      ((edge_v & ~keep_v) == '0) |=> !sts_r[STS_EVT_BIT] || $past(sts_r[STS_EVT_BIT]))
      else $error("dropped edge raised an indication");

   AST_DLY_SWITCH: assert property (@(posedge core_clk) disable iff (sys_rst)
      (act_sel_r != $past(act_sel_r)) |-> $past(win_done))
      else $error("delay changed before window end");

   AST_MOD_ADDR: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rd && hit_mod) |=> wb_ack_o && (wb_dat_o == {16'h0, MOD_ADDR}))
      else $error("module address read wrong");

   AST_INDICATOR: assert property (@(posedge core_clk) disable iff (sys_rst)
      (edge_v != '0) |=> (triggering_input_indicator != 32'h0))
      else $error("indicator empty after an edge");

   COV_EVENT: cover property (@(posedge core_clk) disable iff (sys_rst)
      new_evt ##1 irq);
   COV_DROP: cover property (@(posedge core_clk) disable iff (sys_rst)
      ((edge_v & pend_r) != '0));
   COV_DELAY: cover property (@(posedge core_clk) disable iff (sys_rst)
      dly_evt);
   COV_ACK: cover property (@(posedge core_clk) disable iff (sys_rst)
      (ack_vec & pend_r) != '0);

endmodule
